// ==== core/dfs_sched.sv ====
`timescale 1ns/100ps
// Summary of operation
// RL1: the headend core shapes each flow to match this output's data rate.
// RL2: the headend core can shape to a fraction of our rate so the queue drains faster than it fills.
// RL3: with no data available the output sends null packets until data arrives.
// RL4: data arriving during a null packet waits until that null packet ends, so data starts on a packet boundary.
// RL5: packets arriving during a transmission are queued, never dropped, and sent in order.
// RL6: whenever a queue holds data at a packet boundary it is sent at full output rate, one byte every cycle; in streaming mode maps go first.
// RL7: in packet transport mode a single flow carries everything, maps included, sent in arrival order.
// RL8: in packet streaming mode the headend core puts maps in their own higher-priority flow.
// RL9: in packet streaming mode maps go ahead of queued lower-priority data.
// RL10: the headend scheduler adds map advance margin from the measured delay distribution.
// RL11: in packet streaming mode the map flow has its own queue served with strict priority at each packet boundary.
module dfs_sched
	import dfs_pkg::*;
(
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      arst_n,
	// mode: 0 packet transport, 1 packet streaming
	input  wire logic                      packet_streaming_mode,
	// data flow input (all traffic in packet transport mode)
	input  wire logic [dfs_pkg::DATA_W-1:0] data_in,
	input  wire logic                      data_in_last,
	input  wire logic                      data_in_valid,
	output logic                           data_in_ready,
	// map flow input (packet streaming mode only)
	input  wire logic [dfs_pkg::DATA_W-1:0] map_in,
	input  wire logic                      map_in_last,
	input  wire logic                      map_in_valid,
	output logic                           map_in_ready,
	// transport output, one byte per cycle, never stalls
	output logic [dfs_pkg::DATA_W-1:0]     ts_data,
	output logic                           ts_start,
	output logic                           ts_is_null,
	output dfs_pkg::dfs_src_t              ts_src
);
	import dfs_pkg::*;

	localparam int FW = DATA_W + 1;

	typedef struct packed
	{
		dfs_src_t         src;
		logic [CNT_W-1:0] idx;
		logic [DATA_W-1:0] ts_data;
		logic             ts_start;
		logic             ts_is_null;
		dfs_src_t         ts_src;
	} dfs_state_t;

	dfs_state_t st_reg;
	dfs_state_t st_next;

	logic [FW-1:0] dq_data;
	logic          dq_valid;
	logic          dq_ready;
	logic [FW-1:0] mq_data;
	logic          mq_valid;
	logic          mq_ready;
	logic          map_valid_in;
	logic          map_in_ready_q;
	logic          boundary;
	dfs_src_t      start_src;
	dfs_src_t      cur_src;

	// data (and all of packet transport traffic) queue
	dfs_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_data_q // [RL5] [RL7]
	(
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.in_data   ({data_in_last, data_in}),
		.in_valid  (data_in_valid),
		.in_ready  (data_in_ready),
		.out_data  (dq_data),
		.out_valid (dq_valid),
		.out_ready (dq_ready)
	);

	// map flow queue, ignored in packet transport mode
	assign map_valid_in = map_in_valid && packet_streaming_mode;
	assign map_in_ready = map_in_ready_q && packet_streaming_mode;

	dfs_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_map_q // [RL11]
	(
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.in_data   ({map_in_last, map_in}),
		.in_valid  (map_valid_in),
		.in_ready  (map_in_ready_q),
		.out_data  (mq_data),
		.out_valid (mq_valid),
		.out_ready (mq_ready)
	);

	function automatic logic [DATA_W-1:0] null_byte(input logic [CNT_W-1:0] i);
		case (i)
			'0:        null_byte = NULL_SYNC;
			IDX_PID_H: null_byte = NULL_PID_H;
			IDX_PID_L: null_byte = NULL_PID_L;
			IDX_CTRL:  null_byte = NULL_CTRL;
			default:   null_byte = NULL_FILL;
		endcase
	endfunction

	// source picked at every packet start from the queue heads; maps first in streaming mode.
	// the boundary cycle's tail pop has registered by the time idx is zero, so both valids are current here
	assign start_src = (packet_streaming_mode && mq_valid) ? DFS_SRC_MAP // [RL9] [RL11]
	                 : dq_valid                            ? DFS_SRC_DATA // [RL6] [RL7]
	                 :                                       DFS_SRC_NULL; // [RL3]
	// limitation: a queued packet longer than the index range would be re-decided mid packet
	assign cur_src = (st_reg.idx == '0) ? start_src : st_reg.src;

	// a packet ends after LAST_IDX on nulls, or on the last flag of queued data
	assign boundary = (cur_src == DFS_SRC_NULL) ? (st_reg.idx == LAST_IDX)
	                : (cur_src == DFS_SRC_MAP)  ? (mq_valid && mq_data[DATA_W])
	                :                             (dq_valid && dq_data[DATA_W]);

	always_comb
	begin
		st_next    = st_reg;
		dq_ready   = 1'b0;
		mq_ready   = 1'b0;
		st_next.ts_start = 1'b0;

		// a packet in progress whose queue ran dry pads with fill; the headend shapes
		// whole packets so this only covers an upstream underrun
		case (cur_src)
			DFS_SRC_NULL:
			begin
				st_next.ts_data    = null_byte(st_reg.idx); // [RL3]
				st_next.ts_is_null = 1'b1;
				st_next.ts_start   = (st_reg.idx == '0);
				st_next.idx        = st_reg.idx + 1'b1;
			end
			DFS_SRC_MAP:
			begin
				mq_ready           = 1'b1; // [RL6]
				st_next.ts_data    = mq_valid ? mq_data[DATA_W-1:0] : NULL_FILL;
				st_next.ts_is_null = 1'b0;
				st_next.ts_start   = (st_reg.idx == '0);
				st_next.idx        = mq_valid ? st_reg.idx + 1'b1 : st_reg.idx;
			end
			DFS_SRC_DATA:
			begin
				dq_ready           = 1'b1; // [RL6]
				st_next.ts_data    = dq_valid ? dq_data[DATA_W-1:0] : NULL_FILL;
				st_next.ts_is_null = 1'b0;
				st_next.ts_start   = (st_reg.idx == '0);
				st_next.idx        = dq_valid ? st_reg.idx + 1'b1 : st_reg.idx;
			end
			default:
			begin
				st_next.ts_data    = NULL_FILL;
				st_next.ts_is_null = 1'b1;
				st_next.idx        = '0;
			end
		endcase
		st_next.ts_src = cur_src;
		st_next.src    = cur_src;

		// the source only changes at a packet boundary; the next one is picked a cycle
		// later, once the tail byte's pop has settled, so queued data needs no null gap
		if (boundary) // [RL4]
		begin
			st_next.idx = '0;
			st_next.src = DFS_SRC_NULL;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			st_reg <= '{src: DFS_SRC_NULL, idx: '0, ts_data: '0, ts_start: 1'b0,
			            ts_is_null: 1'b1, ts_src: DFS_SRC_NULL};
		else
			st_reg <= st_next;
	end

	assign ts_data    = st_reg.ts_data;
	assign ts_start   = st_reg.ts_start;
	assign ts_is_null = st_reg.ts_is_null;
	assign ts_src     = st_reg.ts_src;

	// assertions
	a_null_len_fixed: assert property (@(posedge core_clk) disable iff (!arst_n) // [RL4]
		(cur_src == DFS_SRC_NULL && st_reg.idx != LAST_IDX) |=> st_reg.src == DFS_SRC_NULL)
		else $error("null packet cut short");
	a_null_sync_first: assert property (@(posedge core_clk) disable iff (!arst_n) // [RL3]
		(ts_start && ts_is_null) |-> ts_data == NULL_SYNC)
		else $error("null packet without sync byte");
	a_null_when_idle: assert property (@(posedge core_clk) disable iff (!arst_n) // [RL3]
		(st_reg.idx == '0 && !dq_valid && !(mq_valid && packet_streaming_mode)) |=> (ts_start && ts_is_null))
		else $error("idle output not sending nulls");
	a_map_first: assert property (@(posedge core_clk) disable iff (!arst_n) // [RL9]
		(st_reg.idx == '0 && mq_valid && packet_streaming_mode)
		|=> (ts_start && ts_src == DFS_SRC_MAP))
		else $error("map not given priority");
	a_queue_no_gap: assert property (@(posedge core_clk) disable iff (!arst_n) // [RL6]
		(st_reg.idx == '0 && dq_valid) |=> (ts_start && !ts_is_null))
		else $error("null packet sent while data queued");
	a_no_map_transport: assert property (@(posedge core_clk) disable iff (!arst_n) // [RL7]
		!packet_streaming_mode |-> !map_in_ready)
		else $error("map flow taken in transport mode");
	a_data_full_rate: assert property (@(posedge core_clk) disable iff (!arst_n) // [RL6]
		(cur_src == DFS_SRC_DATA && dq_valid) |=> (!ts_is_null && ts_src == DFS_SRC_DATA))
		else $error("queued data not sent at full rate");
	a_switch_boundary: assert property (@(posedge core_clk) disable iff (!arst_n) // [RL11]
		(st_next.src != cur_src) |-> boundary)
		else $error("source changed mid packet");
	a_map_in_order: assert property (@(posedge core_clk) disable iff (!arst_n) // [RL5]
		(cur_src == DFS_SRC_MAP && mq_valid) |=> ts_data == $past(mq_data[DATA_W-1:0]))
		else $error("map byte out of order");

	c_null_to_data: cover property (@(posedge core_clk) disable iff (!arst_n)
		st_reg.src == DFS_SRC_NULL ##1 st_reg.src == DFS_SRC_DATA);
	c_map_preempt: cover property (@(posedge core_clk) disable iff (!arst_n)
		dq_valid && boundary && mq_valid && packet_streaming_mode);
	c_data_queue_full: cover property (@(posedge core_clk) disable iff (!arst_n)
		data_in_valid && !data_in_ready);
	c_data_back_to_back: cover property (@(posedge core_clk) disable iff (!arst_n)
		(boundary && cur_src == DFS_SRC_DATA) ##2 (ts_start && ts_src == DFS_SRC_DATA));
endmodule

// ==== inc/dfs_pkg.sv ====
package dfs_pkg;
	localparam int DATA_W      = 8;
	localparam int PKT_BYTES   = 188;
	localparam int CNT_W       = 8;
	localparam int FIFO_DEPTH  = 4;
	localparam logic [7:0] NULL_SYNC  = 8'h47;
	localparam logic [7:0] NULL_PID_H = 8'h1F;
	localparam logic [7:0] NULL_PID_L = 8'hFF;
	localparam logic [7:0] NULL_CTRL  = 8'h10;
	localparam logic [7:0] NULL_FILL  = 8'hFF;
	localparam logic [CNT_W-1:0] LAST_IDX = 8'hBB;
	localparam logic [CNT_W-1:0] IDX_PID_H = 8'h01;
	localparam logic [CNT_W-1:0] IDX_PID_L = 8'h02;
	localparam logic [CNT_W-1:0] IDX_CTRL  = 8'h03;

	typedef enum logic [1:0]
	{
		DFS_SRC_NULL = 2'b00,
		DFS_SRC_DATA = 2'b01,
		DFS_SRC_MAP  = 2'b10
	} dfs_src_t;
endpackage

// ==== core/dfs_fifo.sv ====
`timescale 1ns/100ps
module dfs_fifo
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
)
(
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	// fill side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// drain side
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// memory kept out of reset; only the pointers and the count carry state that matters
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (pop)
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ==== sim/dfs_head_model.sv ====
`timescale 1ns/100ps
module dfs_head_model
	import dfs_pkg::*;
(
	// clock
	input  wire logic                        core_clk,
	// one shaped flow towards the scheduler
	output logic       [dfs_pkg::DATA_W-1:0] flow_data,
	output logic                             flow_last,
	output logic                             flow_valid,
	input  wire logic                        flow_ready
);
	initial
	begin
		flow_data  = 8'h00;
		flow_last  = 1'b0;
		flow_valid = 1'b0;
	end
	// ready comes from a register, so its value at the falling edge holds at the next rising edge
	task automatic send(input logic [7:0] b, input logic l, output bit ok);
		int n;
		n = 0;
		ok = 1'b0;
		@(negedge core_clk);
		flow_data  = b;
		flow_last  = l;
		flow_valid = 1'b1;
		while (!ok && n < 1000)
		begin
			if (n > 0)
				@(negedge core_clk);
			ok = flow_ready;
			@(posedge core_clk);
			n++;
		end
	endtask
	// released lines show the inverse, never a stale copy of the last byte
	task automatic idle();
		@(negedge core_clk);
		flow_valid = 1'b0;
		flow_data  = ~flow_data;
		flow_last  = ~flow_last;
	endtask
endmodule

// ==== sim/downstream_flow_output_scheduler_tb.sv ====
`timescale 1ns/100ps
module downstream_flow_output_scheduler_tb;
	import dfs_pkg::*;
	logic                core_clk;
	logic                arst_n;
	logic                packet_streaming_mode;
	logic [DATA_W-1:0]   data_in, map_in, ts_data, e;
	logic                data_in_last, data_in_valid, data_in_ready;
	logic                map_in_last, map_in_valid, map_in_ready;
	logic                ts_start, ts_is_null;
	dfs_src_t            ts_src, src_prev;
	logic [7:0]          dq[$], mq[$];
	logic [CNT_W-1:0]    nidx;
	int                  err_count, comparisons, seed;
	bit                  run, map_first;

	dfs_sched uut (.core_clk, .arst_n, .packet_streaming_mode, .data_in, .data_in_last, .data_in_valid,
		.data_in_ready, .map_in, .map_in_last, .map_in_valid, .map_in_ready, .ts_data, .ts_start,
		.ts_is_null, .ts_src);
	dfs_head_model u_data (.core_clk, .flow_data(data_in), .flow_last(data_in_last),
		.flow_valid(data_in_valid), .flow_ready(data_in_ready));
	dfs_head_model u_map (.core_clk, .flow_data(map_in), .flow_last(map_in_last),
		.flow_valid(map_in_valid), .flow_ready(map_in_ready));

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic check(input string nm, input logic [8:0] x, input logic [8:0] s);
		comparisons++;
		if (s !== x)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic [7:0] nbyte(input logic [CNT_W-1:0] i);
		return (i == 0) ? NULL_SYNC : (i == IDX_PID_H) ? NULL_PID_H : (i == IDX_PID_L) ? NULL_PID_L :
			(i == IDX_CTRL) ? NULL_CTRL : NULL_FILL;
	endfunction

	// bytes are noted before they are offered; the watcher pops them in output order
	task automatic send_pkt(input bit f, input int len);
		logic [7:0] b;
		bit         ok;
		for (int i = 0; i < len; i++)
		begin
			b = $random(seed);
			if (f)
				mq.push_back(b);
			else
				dq.push_back(b);
			if (f)
				u_map.send(b, i == len - 1, ok);
			else
				u_data.send(b, i == len - 1, ok);
			if (!ok)
			begin
				err_count++;
				conclude();
			end
		end
		if (f)
			u_map.idle();
		else
			u_data.idle();
	endtask

	// nul: wait for a null packet start, else wait until every noted byte came out
	task automatic wait_for(input bit nul);
		int n;
		n = 0;
		while ((nul ? !(ts_start === 1'b1 && ts_is_null === 1'b1) : (dq.size() + mq.size() > 0)) && n < 2000)
		begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 2000)
		begin
			err_count++;
			conclude();
		end
	endtask

	always @(negedge core_clk)
	begin
		if (run)
		begin
			if (ts_start === 1'b1)
			begin
				if (src_prev === DFS_SRC_NULL)
					check("null_len", {1'b0, LAST_IDX}, {1'b0, nidx});
				if (map_first && ts_is_null !== 1'b1)
				begin
					check("map_first", {7'h00, DFS_SRC_MAP}, {7'h00, ts_src});
					map_first = 1'b0;
				end
				nidx = 8'h00;
			end
			else
			begin
				check("src_hold", {7'h00, src_prev}, {7'h00, ts_src});
				nidx = nidx + 8'h01;
			end
			if (ts_is_null === 1'b1)
				check("null_byte", {1'b0, nbyte(nidx)}, {1'b0, ts_data});
			else if (ts_src === DFS_SRC_MAP)
			begin
				e = (mq.size() > 0) ? mq.pop_front() : 8'hXX;
				check("map_byte", {1'b0, e}, {1'b0, ts_data});
			end
			else
			begin
				e = (dq.size() > 0) ? dq.pop_front() : 8'hXX;
				check("data_byte", {1'b0, e}, {1'b0, ts_data});
			end
			src_prev = ts_src;
		end
	end

	initial
	begin
		seed = 1746;
		err_count = 0;
		comparisons = 0;
		arst_n = 1'b0;
		packet_streaming_mode = 1'b0;
		run = 1'b0;
		map_first = 1'b0;
		src_prev = DFS_SRC_NULL;
		nidx = LAST_IDX;
		repeat (6) @(negedge core_clk);
		check("rst_null", 9'h001, {8'h00, ts_is_null});
		check("map_refused", 9'h000, {8'h00, map_in_ready});
		arst_n = 1'b1;
		@(posedge core_clk);
		run = 1'b1;
		// gaps of zero give back-to-back packets, long gaps give null runs
		for (int p = 0; p < 6; p++)
		begin
			send_pkt(1'b0, 1 + ($random(seed) & 8'h1F));
			repeat ($random(seed) & 8'hFF) @(negedge core_clk);
		end
		wait_for(1'b0);
		packet_streaming_mode = 1'b1;
		for (int p = 0; p < 4; p++)
		begin
			wait_for(1'b1);
			map_first = 1'b1;
			fork
				send_pkt(1'b0, 8 + p);
				send_pkt(1'b1, 2 + p);
			join
			wait_for(1'b0);
		end
		conclude();
	end
endmodule
